// file: hirc_regs.svh
// Offsets, field positions, key values and timing figures of the block.
`ifndef HIRC_REGS_SVH
`define HIRC_REGS_SVH

`define IRQ_SRC_ADDR 8'h00
`define DUTY_MODE_ADDR 7'h07
`define IRQ_MASK_ADDR 7'h09
`define RESET_KEY_ADDR 8'hff
`define RESET_KEY_FIRST 8'hde
`define RESET_KEY_SECOND 8'h00
`define SLAVE_ADDR 7'h2b
`define NVM_LAST_IDX 7'h5e
`define DUTY_IRQ_BIT 0
`define DUTY_RESET 1'h1
`define IRQ_MASK_RESET 4'hf
`define CLK_MHZ 200
`define SETTLE_TIME_US 500
`define SCAN_PERIOD_US 30000
`define SETTLE_CYCLES (`SETTLE_TIME_US * `CLK_MHZ)
`define SCAN_CYCLES (`SCAN_PERIOD_US * `CLK_MHZ)

`endif

// file: hirc_pkg.sv
// State types of the host interrupt and reset controller.
package hirc_pkg;
  typedef enum logic [1:0] {
    seq_reset, seq_settle, seq_load, seq_run
  } seq_state_e;
  typedef enum logic [3:0] {
    i2c_idle, i2c_addr, i2c_addr_ack, i2c_ptr, i2c_ptr_ack,
    i2c_wdata, i2c_wdata_ack, i2c_rdata, i2c_rd_mack
  } i2c_state_e;
endpackage

// file: reg_store.sv
// Register storage with one write port and a registered read port.
`timescale 1ns/1ps
module reg_store (
  input wire logic ref_clk, // Clock
  input wire logic we, // Write strobe
  input wire logic [6:0] waddr, // Write address
  input wire logic [7:0] wdata, // Write data
  input wire logic [6:0] raddr, // Read address
  output logic [7:0] rdata_q // Read data, one cycle after raddr
);
  logic [7:0] mem [0:127];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

// file: host_irq_ctrl.sv
// Host interrupt line, reset sequencing and register port of the controller.
`timescale 1ns/1ps
`include "hirc_regs.svh"
// Behaviour
// - Interrupt held low during power-up when configured for interrupt duty.
// - Interrupt released by itself when power-up ends.
// - Analog output levels updated within one scan period after release.
// - Register access accepted once the interrupt has risen.
// - Interrupt re-evaluated once per scan period.
// - Touch, and release when enabled, assert the interrupt.
// - Proximity gained or lost asserts the interrupt.
// - Completed compensation asserts the interrupt.
// - Interrupt held asserted during every kind of reset when configured for interrupt duty.
// - Any register read clears the pending interrupt.
// - Three reset sources: power-up, reset pin, software key.
// - Reset pin low holds reset; full power-up follows its rise.
// - Writing 0xDE then 0x00 to address 0xFF resets the device.
// - Clocks settle and registers initialise before readiness.
// - Register settings load from nonvolatile storage after any reset.
// - Serial slave answers at seven-bit address 0x2B.
module host_irq_ctrl #(
  parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES, // Settle wait
  parameter int unsigned SCAN_CYCLES = `SCAN_CYCLES // Scan period
) (
  input wire logic ref_clk, // 200 MHz clock
  input wire logic rst_n, // Power-up reset, active low
  input wire logic hw_reset_n, // Hardware reset pin, active low
  input wire logic scl_in, // Serial clock level
  input wire logic sda_in, // Serial data level
  output logic sda_out, // Serial data drive value, always low
  output logic sda_oe, // Serial data pull-down enable
  output logic host_irq_n, // Interrupt drive value, always low
  output logic host_irq_oe, // Interrupt pull-down enable
  input wire logic touch_evt, // Button touch event pulse
  input wire logic release_evt, // Button release event pulse
  input wire logic prox_evt, // Proximity detected pulse
  input wire logic prox_loss_evt, // Proximity lost pulse
  input wire logic comp_done_evt, // Compensation done pulse
  input wire logic [11:0] analog_level_in, // New analog levels
  output logic [11:0] analog_output_level, // Analog levels in use
  output logic [6:0] nvm_addr, // Nonvolatile storage address
  input wire logic [7:0] nvm_rdata, // Data at nvm_addr, same cycle
  output logic ready // High in normal operation
);
  logic rst_m_q, rst_sync_q;
  hirc_pkg::seq_state_e seq_q, seq_d;
  hirc_pkg::i2c_state_e st_q, st_d;
  logic [31:0] cnt_q, cnt_d, scan_q, scan_d;
  logic [6:0] idx_q, idx_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, byte_v, rd_byte, mem_rdata;
  logic ph_q, ph_d, oe_q, oe_d, armed_q, armed_d;
  logic scl_q, sda_q, duty_q, duty_d, irq_q, irq_d, pend_q, pend_d;
  logic ready_q, ready_d;
  logic [3:0] mask_q, mask_d, src_q, src_d, evt_vec;
  logic [11:0] level_q, level_d;
  logic scl_rise, scl_fall, start_c, stop_c, tick, any_evt, in_run;
  logic wr_hit, rd_start, src_rd, soft_rst, mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_sync_q <= rst_m_q;
    end
  end

  assign in_run = (seq_q == hirc_pkg::seq_run);
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_c = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c = scl_in & scl_q & ~sda_q & sda_in;
  assign byte_v = {sh_q[6:0], sda_in};
  assign rd_byte = (ptr_q == `IRQ_SRC_ADDR) ? {4'h0, src_q} :
                   (ptr_q[7] ? 8'h00 : mem_rdata);

  // Reset and power-up sequence.
  always_comb begin
    seq_d = seq_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    case (seq_q)
      hirc_pkg::seq_reset: begin
        cnt_d = 32'h0000_0000;
        idx_d = 7'h00;
        if (hw_reset_n) seq_d = hirc_pkg::seq_settle;
      end
      hirc_pkg::seq_settle: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (cnt_q == SETTLE_CYCLES - 1) seq_d = hirc_pkg::seq_load;
      end
      hirc_pkg::seq_load: begin
        idx_d = idx_q + 7'h01;
        if (idx_q == `NVM_LAST_IDX) seq_d = hirc_pkg::seq_run;
      end
      hirc_pkg::seq_run: begin
        seq_d = seq_q;
      end
      default: seq_d = hirc_pkg::seq_reset;
    endcase
    if (!hw_reset_n || soft_rst) begin
      seq_d = hirc_pkg::seq_reset;
    end
    ready_d = (seq_d == hirc_pkg::seq_run);
  end

  // Serial slave; idle whenever the device is not running.
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    ph_d = ph_q;
    oe_d = oe_q;
    armed_d = in_run ? armed_q : 1'b0;
    wr_hit = 1'b0;
    rd_start = 1'b0;
    src_rd = 1'b0;
    soft_rst = 1'b0;
    if (!in_run || stop_c) begin
      st_d = hirc_pkg::i2c_idle;
      oe_d = 1'b0;
    end else if (start_c) begin
      st_d = hirc_pkg::i2c_addr;
      bit_d = 3'h0;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        hirc_pkg::i2c_addr, hirc_pkg::i2c_ptr, hirc_pkg::i2c_wdata: begin
          if (scl_rise) begin
            sh_d = byte_v;
            bit_d = bit_q + 3'h1;
            ph_d = 1'b0;
            if (bit_q == 3'h7) begin
              if (st_q == hirc_pkg::i2c_addr) begin
                if (byte_v[7:1] == `SLAVE_ADDR) begin
                  st_d = hirc_pkg::i2c_addr_ack;
                  rd_start = byte_v[0];
                end else begin
                  st_d = hirc_pkg::i2c_idle;
                end
              end else if (st_q == hirc_pkg::i2c_ptr) begin
                ptr_d = byte_v;
                st_d = hirc_pkg::i2c_ptr_ack;
              end else begin
                wr_hit = 1'b1;
                ptr_d = ptr_q + 8'h01;
                st_d = hirc_pkg::i2c_wdata_ack;
                if (ptr_q == `RESET_KEY_ADDR) begin
                  armed_d = (byte_v == `RESET_KEY_FIRST);
                  soft_rst = armed_q && (byte_v == `RESET_KEY_SECOND);
                end
              end
            end
          end
        end
        hirc_pkg::i2c_addr_ack, hirc_pkg::i2c_ptr_ack,
        hirc_pkg::i2c_wdata_ack: begin
          if (scl_fall) begin
            bit_d = 3'h0;
            ph_d = ~ph_q;
            if (!ph_q) begin
              oe_d = 1'b1;
            end else if (st_q == hirc_pkg::i2c_addr_ack && sh_q[0]) begin
              st_d = hirc_pkg::i2c_rdata;
              sh_d = rd_byte;
              oe_d = ~rd_byte[7];
              src_rd = (ptr_q == `IRQ_SRC_ADDR);
            end else begin
              oe_d = 1'b0;
              st_d = (st_q == hirc_pkg::i2c_addr_ack) ?
                     hirc_pkg::i2c_ptr : hirc_pkg::i2c_wdata;
            end
          end
        end
        hirc_pkg::i2c_rdata: begin
          if (scl_fall) begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = ~sh_q[6];
          end else if (scl_rise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_d = hirc_pkg::i2c_rd_mack;
              ph_d = 1'b0;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        hirc_pkg::i2c_rd_mack: begin
          if (scl_fall && !ph_q) begin
            ph_d = 1'b1;
            oe_d = 1'b0;
          end else if (scl_rise && ph_q && sda_in) begin
            st_d = hirc_pkg::i2c_idle;
          end else if (scl_fall) begin
            ph_d = 1'b0;
            bit_d = 3'h0;
            st_d = hirc_pkg::i2c_rdata;
            sh_d = rd_byte;
            oe_d = ~rd_byte[7];
            src_rd = (ptr_q == `IRQ_SRC_ADDR);
          end
        end
        default: st_d = hirc_pkg::i2c_idle;
      endcase
    end
    // A reset from the pin or the key also drops a transfer in flight.
    if (!hw_reset_n || soft_rst) begin
      st_d = hirc_pkg::i2c_idle;
      oe_d = 1'b0;
    end
  end

  // Storage port is shared by the load sequence and host writes.
  always_comb begin
    mem_we = (seq_q == hirc_pkg::seq_load) ||
             (wr_hit && !ptr_q[7] && ptr_q != `IRQ_SRC_ADDR);
    mem_waddr = (seq_q == hirc_pkg::seq_load) ? idx_q : ptr_q[6:0];
    mem_wdata = (seq_q == hirc_pkg::seq_load) ? nvm_rdata : byte_v;
    duty_d = duty_q;
    mask_d = mask_q;
    if (mem_we && mem_waddr == `DUTY_MODE_ADDR) begin
      duty_d = mem_wdata[`DUTY_IRQ_BIT];
    end
    if (mem_we && mem_waddr == `IRQ_MASK_ADDR) begin
      mask_d = mem_wdata[3:0];
    end
  end

  reg_store u_store (
    .ref_clk(ref_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(ptr_q[6:0]),
    .rdata_q(mem_rdata)
  );

  // Scan period, pending events and the interrupt line.
  always_comb begin
    evt_vec = {comp_done_evt, prox_evt | prox_loss_evt, release_evt,
               touch_evt} & mask_q;
    any_evt = in_run && (|evt_vec);
    tick = in_run && (scan_q == SCAN_CYCLES - 1);
    scan_d = (!in_run || tick) ? 32'h0000_0000 : scan_q + 32'h0000_0001;
    src_d = in_run ? ((src_q & ~{4{src_rd}}) | evt_vec) : 4'h0;
    if (!in_run) begin
      pend_d = 1'b0;
    end else if (tick) begin
      pend_d = 1'b0;
    end else begin
      pend_d = pend_q | any_evt;
    end
    if (seq_d != hirc_pkg::seq_run) begin
      irq_d = duty_q;
    end else if (!in_run || !duty_q) begin
      irq_d = 1'b0;
    end else if (tick && (pend_q || any_evt)) begin
      irq_d = 1'b1;
    end else if (rd_start) begin
      irq_d = 1'b0;
    end else begin
      irq_d = irq_q;
    end
    level_d = tick ? analog_level_in : level_q;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      seq_q <= hirc_pkg::seq_reset;
      st_q <= hirc_pkg::i2c_idle;
      cnt_q <= 32'h0000_0000;
      scan_q <= 32'h0000_0000;
      idx_q <= 7'h00;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      ph_q <= 1'b0;
      oe_q <= 1'b0;
      armed_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      duty_q <= `DUTY_RESET;
      mask_q <= `IRQ_MASK_RESET;
      src_q <= 4'h0;
      pend_q <= 1'b0;
      irq_q <= 1'b1;
      level_q <= 12'h000;
      ready_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      scan_q <= scan_d;
      idx_q <= idx_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      ph_q <= ph_d;
      oe_q <= oe_d;
      armed_q <= armed_d;
      scl_q <= scl_in;
      sda_q <= sda_in;
      duty_q <= duty_d;
      mask_q <= mask_d;
      src_q <= src_d;
      pend_q <= pend_d;
      irq_q <= irq_d;
      level_q <= level_d;
      ready_q <= ready_d;
    end
  end

  assign sda_out = 1'b0;
  assign host_irq_n = 1'b0;
  assign sda_oe = oe_q;
  assign host_irq_oe = irq_q;
  assign analog_output_level = level_q;
  assign nvm_addr = idx_q;
  assign ready = ready_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_q);

  chk_reset_irq_low: assert property (
    (seq_d != hirc_pkg::seq_run && duty_q) |=> host_irq_oe)
    else $error("interrupt not held during reset");
  chk_powerup_release: assert property (
    (seq_q == hirc_pkg::seq_load && seq_d == hirc_pkg::seq_run)
    |=> !host_irq_oe && ready)
    else $error("interrupt not released at end of power-up");
  chk_level_follows: assert property (
    tick |=> analog_output_level == $past(analog_level_in))
    else $error("analog levels not updated on scan tick");
  chk_access_gate: assert property (
    st_q != hirc_pkg::i2c_idle |-> in_run)
    else $error("serial access outside normal operation");
  chk_read_clear: assert property (
    (rd_start && !tick) |=> !host_irq_oe)
    else $error("read did not clear interrupt");
  chk_event_assert: assert property (
    (tick && pend_q && duty_q) |=> host_irq_oe [*1] ##1 1'b1)
    else $error("pending event did not assert interrupt");
  chk_soft_key: assert property (
    soft_rst |=> seq_q == hirc_pkg::seq_reset ##1
    (seq_q != hirc_pkg::seq_run))
    else $error("key sequence did not reset");
  chk_pin_reset: assert property (
    !hw_reset_n |=> seq_q == hirc_pkg::seq_reset && !ready)
    else $error("reset pin did not hold reset");
  chk_load_all: assert property (
    $rose(in_run) |-> $past(idx_q) == `NVM_LAST_IDX)
    else $error("run entered before full load");
endmodule

// file: host_bus_model.sv
// Host side model: serial bus master that drives the clock directly, with open-drain data.
`timescale 1ns/1ps
module host_bus_model (
  input wire logic ref_clk, // Clock
  input wire logic sda_oe, // Slave pulls data low
  output logic scl_in, // Serial clock wire
  output logic sda_in // Serial data wire
);
  logic scl_q = 1'b1;
  logic pull_q = 1'b0;
  // The data wire has a pull-up, so a released line reads high.
  assign scl_in = scl_q;
  assign sda_in = ~(sda_oe | pull_q);
  task automatic half();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  task automatic start();
    pull_q = 1'b0;
    half();
    scl_q = 1'b1;
    half();
    pull_q = 1'b1;
    half();
    scl_q = 1'b0;
  endtask
  task automatic stop();
    pull_q = 1'b1;
    half();
    scl_q = 1'b1;
    half();
    pull_q = 1'b0;
    half();
  endtask
  // Nine clock pulses: eight data bits, then the acknowledge slot.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      pull_q = ~tx[i];
      half();
      scl_q = 1'b1;
      half();
      rx[i] = sda_in;
      scl_q = 1'b0;
    end
  endtask
endmodule

// file: testbench.sv
// Testbench of the host interrupt and reset controller.
`timescale 1ns/1ps
`include "hirc_regs.svh"
module testbench;
  localparam int SCAN = 64;
  // Settle cycles plus one cycle per word loaded from storage.
  localparam int INIT = 8 + 95;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hw_reset_n = 1'b1;
  logic [4:0] evt = 5'h0;
  logic [11:0] level = 12'h000;
  logic scl_in, sda_in, sda_out, sda_oe, host_irq_n, host_irq_oe, ready;
  logic [11:0] analog_output_level;
  logic [6:0] nvm_addr;
  logic [8:0] rx;
  logic [7:0] src [5] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08};
  int fails = 0;
  int total_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  host_irq_ctrl #(.SETTLE_CYCLES(8), .SCAN_CYCLES(SCAN)) host_irq_ctrl_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .hw_reset_n(hw_reset_n),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .host_irq_n(host_irq_n), .host_irq_oe(host_irq_oe),
    .touch_evt(evt[0]), .release_evt(evt[1]), .prox_evt(evt[2]),
    .prox_loss_evt(evt[3]), .comp_done_evt(evt[4]),
    .analog_level_in(level),
    .analog_output_level(analog_output_level), .nvm_addr(nvm_addr),
    .nvm_rdata({1'b1, nvm_addr}), .ready(ready));
  host_bus_model host_bus_model_i (
    .ref_clk(ref_clk), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));
  task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic addr_ptr(logic [7:0] a);
    host_bus_model_i.start();
    host_bus_model_i.xfer({`SLAVE_ADDR, 1'b0, 1'b1}, rx);
    check("addr_ack", rx[0], 1'b0);
    host_bus_model_i.xfer({a, 1'b1}, rx);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    addr_ptr(a);
    host_bus_model_i.xfer({d, 1'b1}, rx);
    host_bus_model_i.stop();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    addr_ptr(a);
    host_bus_model_i.start();
    host_bus_model_i.xfer({`SLAVE_ADDR, 1'b1, 1'b1}, rx);
    host_bus_model_i.xfer(9'h1ff, rx);
    host_bus_model_i.stop();
    check("read_data", rx[8:1], exp);
  endtask
  task automatic in_reset();
    check("reset_irq", host_irq_oe, 1'b1);
    check("reset_ready", ready, 1'b0);
    check("irq_drive", host_irq_n, 1'b0);
    check("data_drive", sda_out, 1'b0);
    check("reset_no_ack", sda_oe, 1'b0);
  endtask
  task automatic wait_ready(int lo);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    check("ready", ready, 1'b1);
    check("irq_free", host_irq_oe, 1'b0);
    check("init_time", n >= lo, 1'b1);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (host_irq_oe !== 1'b1 && n < SCAN + 4) begin
      tick(1);
      n++;
    end
    check("irq_set", host_irq_oe, 1'b1);
  endtask
  task automatic pulse(int i);
    evt[i] = 1'b1;
    tick(1);
    evt = 5'h0;
  endtask
  initial begin
    tick(40000);
    fails++;
    give_verdict();
  end
  initial begin
    tick(5);
    in_reset();
    rst_n = 1'b1;
    tick(20);
    in_reset();
    wait_ready(INIT - 20);
    level = 12'h5a3;
    tick(SCAN + 2);
    check("analog_level", analog_output_level, 12'h5a3);
    rd(8'h09, 8'h89);
    rd(8'hff, 8'h00);
    host_bus_model_i.start();
    host_bus_model_i.xfer({7'h2a, 1'b0, 1'b1}, rx);
    host_bus_model_i.stop();
    check("foreign_addr", rx[0], 1'b1);
    wr(8'h09, 8'h0f);
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      wait_irq();
      rd(8'h09, 8'h0f);
      check("irq_clear", host_irq_oe, 1'b0);
      rd(8'h00, src[i]);
    end
    wr(8'h09, 8'h0d);
    pulse(1);
    tick(SCAN + 8);
    check("masked", host_irq_oe, 1'b0);
    wr(8'hff, 8'hde);
    wr(8'hff, 8'h55);
    wr(8'hff, 8'h00);
    tick(4);
    check("disarmed", ready, 1'b1);
    wr(8'hff, 8'hde);
    wr(8'hff, 8'h00);
    in_reset();
    // The key write spends 48 cycles on the bus after the reset edge.
    wait_ready(INIT - 48);
    rd(8'h09, 8'h89);
    hw_reset_n = 1'b0;
    tick(3);
    in_reset();
    tick(50);
    in_reset();
    hw_reset_n = 1'b1;
    wait_ready(INIT);
    give_verdict();
  end
endmodule
